// [design/erx_filter.sv]
// Receive channel filter, address RAM, QoS drop and teardown engine
// Summary of operation
// - Eight channels, enables via set/clear registers
// - Broadcast goes to one chosen channel
// - Hashed group address selects multicast channel
// - Promiscuous channel with three class enables
// - RAM multicast gated by channel enables
// - RAM filter drops; RAM match overrides hash
// - Address RAM: 32 entries of 53 bits
// - Filter entry channel field is ignored
// - Type 8100h tagged, priority from TCI
// - Priority 4-7 high, rest low
// - QoS drops low frames at threshold
// - Buffer use decrements, host write adds
// - Free counters hold up to 65535
// - Teardown waits for current frame end
// - Teardown clears head, raises interrupt, sets completion pointer to FFFFFFFCh
// - Teardown any time, enables untouched
// - Inactive channel teardown: interrupt, no descriptor
// - Disabled channels non-matching for RAM entries only; filter entries drop
//
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
`include "erx_map.svh"
module erx_filter (
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic [7:0]         reg_addr,
  input  wire logic [31:0]        reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic [31:0]             reg_rdata,
  input  wire logic               hdr_valid,
  input  wire erx_pkg::erx_mac_t  hdr_dest,
  input  wire logic [15:0]        hdr_len_type,
  input  wire logic [15:0]        hdr_tci,
  input  wire logic               hdr_is_control,
  input  wire logic               hdr_is_short,
  input  wire logic               hdr_has_error,
  output logic                    route_valid,
  output logic                    route_accept,
  output erx_pkg::erx_chan_t      route_chan,
  output logic                    route_prio_high,
  input  wire logic               buf_used,
  input  wire erx_pkg::erx_chan_t buf_used_chan,
  input  wire logic               rx_frame_busy,
  input  wire erx_pkg::erx_chan_t rx_frame_chan,
  output logic [7:0]              rx_irq,
  output logic                    td_desc_flag_wr,
  output logic [31:0]             td_desc_ptr
);
  import erx_pkg::*;

  // ============================================================
  // Register state
  logic [31:0]  cfg_reg;
  logic [7:0]   chan_en_reg;
  logic [31:0]  hash_lo_reg;
  logic [31:0]  hash_hi_reg;
  logic [15:0]  thr_reg;
  logic [4:0]   ram_index_reg;
  logic [31:0]  ram_upper_reg;
  logic [47:0]  ram_addr_reg [`ERX_RAM_DEPTH];
  erx_chan_t    ram_chan_reg [`ERX_RAM_DEPTH];
  logic [31:0]  ram_valid_reg;
  logic [31:0]  ram_mf_reg;
  logic [15:0]  free_reg [`ERX_NUM_CHAN];
  logic [31:0]  hdp_reg [`ERX_NUM_CHAN];
  logic [31:0]  cp_reg [`ERX_NUM_CHAN];
  logic [7:0]   td_pend_reg;
  logic [31:0]  rdata_next;

  logic         wr_cfg;
  logic         wr_set;
  logic         wr_clr;
  logic         wr_td;
  logic         arr_hit_free;
  logic         arr_hit_hdp;
  logic         arr_hit_cp;
  erx_chan_t    arr_idx;

  assign arr_idx      = reg_addr[4:2];
  assign arr_hit_free = (reg_addr & ~(`ERX_ARRAY_SPAN - 8'h01)) == `ERX_OFS_FREE_BASE;
  assign arr_hit_hdp  = (reg_addr & ~(`ERX_ARRAY_SPAN - 8'h01)) == `ERX_OFS_HDP_BASE;
  assign arr_hit_cp   = (reg_addr & ~(`ERX_ARRAY_SPAN - 8'h01)) == `ERX_OFS_CP_BASE;
  assign wr_cfg       = reg_wr && reg_addr == `ERX_OFS_FILTER_CFG;
  assign wr_set       = reg_wr && reg_addr == `ERX_OFS_CHEN_SET;
  assign wr_clr       = reg_wr && reg_addr == `ERX_OFS_CHEN_CLR;
  assign wr_td        = reg_wr && reg_addr == `ERX_OFS_TEARDOWN;

  // ============================================================
  // Configuration registers
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      cfg_reg     <= `ERX_CFG_RESET;
      hash_lo_reg <= 32'h0000_0000;
      hash_hi_reg <= 32'h0000_0000;
      thr_reg     <= 16'h0000;
    end else if (reg_wr) begin
      if (wr_cfg) begin
        cfg_reg <= reg_wdata;
      end else if (reg_addr == `ERX_OFS_HASH_LO) begin
        hash_lo_reg <= reg_wdata;
      end else if (reg_addr == `ERX_OFS_HASH_HI) begin
        hash_hi_reg <= reg_wdata;
      end else if (reg_addr == `ERX_OFS_LOWPRIO_THR) begin
        thr_reg <= reg_wdata[15:0];
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      chan_en_reg <= 8'h00;
    end else if (wr_set) begin
      chan_en_reg <= chan_en_reg | reg_wdata[7:0];
    end else if (wr_clr) begin
      chan_en_reg <= chan_en_reg & ~reg_wdata[7:0];
    end
  end

  // ============================================================
  // Address RAM programming
  // lower word commits entry
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      ram_index_reg <= 5'h00;
      ram_upper_reg <= 32'h0000_0000;
      ram_valid_reg <= 32'h0000_0000;
      ram_mf_reg    <= 32'h0000_0000;
    end else if (reg_wr) begin
      if (reg_addr == `ERX_OFS_RAM_INDEX) begin
        ram_index_reg <= reg_wdata[4:0];
      end else if (reg_addr == `ERX_OFS_RAM_UPPER) begin
        ram_upper_reg <= reg_wdata;
      end else if (reg_addr == `ERX_OFS_RAM_LOWER) begin
        ram_valid_reg[ram_index_reg] <= reg_wdata[`ERX_LOW_VALID_BIT];
        ram_mf_reg[ram_index_reg]    <= reg_wdata[`ERX_LOW_MF_BIT];
      end
    end
  end

  // 48-bit address plus channel per entry
  always_ff @(posedge core_clk) begin
    if (reg_wr && reg_addr == `ERX_OFS_RAM_LOWER) begin
      ram_addr_reg[ram_index_reg] <= {ram_upper_reg, reg_wdata[15:0]};
      ram_chan_reg[ram_index_reg] <= reg_wdata[`ERX_LOW_CH_LSB +: 3];
    end
  end

  // ============================================================
  // Frame classification
  logic [31:0]  ram_match;
  logic         ram_hit;
  logic         ram_mf;
  erx_chan_t    ram_chan;
  logic         hash_hit;
  logic         is_bcast;
  logic         is_group;
  logic         prio_high_c;
  logic         class_ok;
  logic         matched_c;
  logic         qos_drop_c;
  erx_chan_t    match_chan;
  erx_chan_t    final_chan;
  erx_route_e   route_c;

  // Unwritten entries are masked by the valid bit, so no RAM reset
  for (genvar e = 0; e < `ERX_RAM_DEPTH; e++) begin : g_cam
    assign ram_match[e] = ram_valid_reg[e] && ram_addr_reg[e] == hdr_dest;
  end

  // Lowest matching entry wins
  always_comb begin
    ram_hit  = 1'b0;
    ram_mf   = 1'b0;
    ram_chan = 3'h0;
    for (int e = `ERX_RAM_DEPTH - 1; e >= 0; e--) begin
      if (ram_match[e]) begin
        ram_hit  = 1'b1;
        ram_mf   = ram_mf_reg[e];
        ram_chan = ram_chan_reg[e];
      end
    end
  end

  erx_hash u_hash (
    .dest_addr  (hdr_dest),
    .hash_lo    (hash_lo_reg),
    .hash_hi    (hash_hi_reg),
    .hash_index (),
    .hash_hit   (hash_hit)
  );

  assign is_bcast = hdr_dest == `ERX_BCAST_ADDR;
  assign is_group = hdr_dest[`ERX_GROUP_BIT];

  // upper half of range is high
  assign prio_high_c = hdr_len_type == `ERX_TPID_TAGGED && hdr_tci[`ERX_PRIO_MSB];

  assign class_ok = (!hdr_is_control || cfg_reg[`ERX_CFG_CTRL_EN])
                 && (!hdr_is_short   || cfg_reg[`ERX_CFG_SHORT_EN])
                 && (!hdr_has_error  || cfg_reg[`ERX_CFG_ERR_EN]);

  always_comb begin
    matched_c  = 1'b0;
    match_chan = 3'h0;
    if (ram_hit) begin
      matched_c  = ram_mf && chan_en_reg[ram_chan];
      match_chan = ram_chan;
    end else if (is_bcast) begin
      matched_c  = cfg_reg[`ERX_CFG_BCAST_EN];
      match_chan = cfg_reg[`ERX_CFG_BCH_LSB +: 3];
    end else if (is_group) begin
      matched_c  = hash_hit && cfg_reg[`ERX_CFG_MCAST_EN];
      match_chan = cfg_reg[`ERX_CFG_MCH_LSB +: 3];
    end
    // Control frames only address match when accepted
    if (hdr_is_control && !cfg_reg[`ERX_CFG_CTRL_EN]) begin
      matched_c = 1'b0;
    end
  end

  always_comb begin
    route_c    = ERX_ROUTE_DROP;
    final_chan = match_chan;
    // filter hit drops even hash match
    if (ram_hit && !ram_mf) begin
      route_c = ERX_ROUTE_DROP;
    end else if (matched_c) begin
      route_c = class_ok ? ERX_ROUTE_MATCH : ERX_ROUTE_DROP;
    end else if (cfg_reg[`ERX_CFG_ALL_EN] && class_ok) begin
      route_c    = ERX_ROUTE_PROMISC;
      final_chan = cfg_reg[`ERX_CFG_PCH_LSB +: 3];
    end
  end

  assign qos_drop_c = cfg_reg[`ERX_CFG_QOS_EN] && !prio_high_c
                   && free_reg[final_chan] <= thr_reg;

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      route_valid     <= 1'b0;
      route_accept    <= 1'b0;
      route_chan      <= 3'h0;
      route_prio_high <= 1'b0;
    end else begin
      route_valid     <= hdr_valid;
      route_accept    <= hdr_valid && route_c != ERX_ROUTE_DROP && !qos_drop_c;
      route_chan      <= final_chan;
      route_prio_high <= prio_high_c;
    end
  end

  // ============================================================
  // Free buffer counters
  for (genvar c = 0; c < `ERX_NUM_CHAN; c++) begin : g_free
    logic [17:0] sum;
    logic [15:0] add;
    logic        sub;
    assign add = (reg_wr && arr_hit_free && arr_idx == c) ? reg_wdata[15:0] : 16'h0000;
    assign sub = buf_used && buf_used_chan == c;
    assign sum = {2'b00, free_reg[c]} + {2'b00, add} - {17'h00000, sub};
    // add on write, subtract on use
    always_ff @(posedge core_clk or posedge reset) begin
      if (reset) begin
        free_reg[c] <= 16'h0000;
      end else if (sum[17]) begin
        free_reg[c] <= 16'h0000;
      end else if (sum[16]) begin
        free_reg[c] <= `ERX_FREE_MAX;
      end else begin
        free_reg[c] <= sum[15:0];
      end
    end
  end

  // ============================================================
  // Teardown engine, one channel per cycle
  logic         td_serve;
  erx_chan_t    td_sel;
  logic         td_active;

  always_comb begin
    td_serve = 1'b0;
    td_sel   = 3'h0;
    for (int c = `ERX_NUM_CHAN - 1; c >= 0; c--) begin
      if (td_pend_reg[c] && !(rx_frame_busy && rx_frame_chan == 3'(c))) begin
        td_serve = 1'b1;
        td_sel   = 3'(c);
      end
    end
  end

  assign td_active = hdp_reg[td_sel] != 32'h0000_0000;

  // accepted any time; new request wins over completion
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      td_pend_reg <= 8'h00;
    end else begin
      td_pend_reg <= (td_pend_reg & ~(td_serve ? 8'h01 << td_sel : 8'h00))
                   | (wr_td ? 8'h01 << reg_wdata[2:0] : 8'h00);
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      rx_irq          <= 8'h00;
      td_desc_flag_wr <= 1'b0;
      td_desc_ptr     <= 32'h0000_0000;
    end else begin
      rx_irq          <= td_serve ? 8'h01 << td_sel : 8'h00;
      td_desc_flag_wr <= td_serve && td_active;
      td_desc_ptr     <= hdp_reg[td_sel];
    end
  end

  // Host load of a head pointer outranks a clear in the same cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      for (int c = 0; c < `ERX_NUM_CHAN; c++) begin
        hdp_reg[c] <= 32'h0000_0000;
        cp_reg[c]  <= 32'h0000_0000;
      end
    end else begin
      if (td_serve) begin
        hdp_reg[td_sel] <= 32'h0000_0000;
        cp_reg[td_sel]  <= `ERX_TD_CP_VALUE;
      end
      if (reg_wr && arr_hit_hdp) begin
        hdp_reg[arr_idx] <= reg_wdata;
      end
      if (reg_wr && arr_hit_cp) begin
        cp_reg[arr_idx] <= reg_wdata;
      end
    end
  end

  // ============================================================
  // Read path, unmapped reads return zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_addr == `ERX_OFS_FILTER_CFG) begin
      rdata_next = cfg_reg;
    end else if (reg_addr == `ERX_OFS_CHEN_SET || reg_addr == `ERX_OFS_CHEN_CLR) begin
      rdata_next = {24'h000000, chan_en_reg};
    end else if (reg_addr == `ERX_OFS_HASH_LO) begin
      rdata_next = hash_lo_reg;
    end else if (reg_addr == `ERX_OFS_HASH_HI) begin
      rdata_next = hash_hi_reg;
    end else if (reg_addr == `ERX_OFS_LOWPRIO_THR) begin
      rdata_next = {16'h0000, thr_reg};
    end else if (reg_addr == `ERX_OFS_RAM_INDEX) begin
      rdata_next = {27'h0000000, ram_index_reg};
    end else if (reg_addr == `ERX_OFS_RAM_UPPER) begin
      rdata_next = ram_upper_reg;
    end else if (reg_addr == `ERX_OFS_TEARDOWN) begin
      rdata_next = {24'h000000, td_pend_reg};
    end else if (arr_hit_free) begin
      rdata_next = {16'h0000, free_reg[arr_idx]};
    end else if (arr_hit_hdp) begin
      rdata_next = hdp_reg[arr_idx];
    end else if (arr_hit_cp) begin
      rdata_next = cp_reg[arr_idx];
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      reg_rdata <= 32'h0000_0000;
    end else begin
      reg_rdata <= reg_rd ? rdata_next : 32'h0000_0000;
    end
  end

  // ============================================================
  // Assertions
  AST_ROUTE_LATENCY: assert property (@(posedge core_clk) disable iff (reset)
    hdr_valid |=> route_valid ##1 !route_valid || $past(hdr_valid))
    else $error("route answer not one cycle after header");
  AST_BCAST_CHAN: assert property (@(posedge core_clk) disable iff (reset)
    (hdr_valid && route_c == ERX_ROUTE_MATCH && is_bcast && !ram_hit)
    |=> route_chan == $past(cfg_reg[`ERX_CFG_BCH_LSB +: 3]))
    else $error("broadcast sent to wrong channel");
  AST_FILTER_DROP: assert property (@(posedge core_clk) disable iff (reset)
    (hdr_valid && ram_hit && !ram_mf) |=> !route_accept)
    else $error("filter entry did not drop frame");
  AST_RAM_OVER_HASH: assert property (@(posedge core_clk) disable iff (reset)
    (hdr_valid && ram_hit && ram_mf && chan_en_reg[ram_chan] && class_ok && !qos_drop_c)
    |=> route_accept && route_chan == $past(ram_chan))
    else $error("enabled RAM entry not routed");
  AST_QOS_DROP: assert property (@(posedge core_clk) disable iff (reset)
    (hdr_valid && qos_drop_c) |=> !route_accept)
    else $error("low priority frame passed at threshold");
  AST_FREE_DEC: assert property (@(posedge core_clk) disable iff (reset)
    (buf_used && buf_used_chan == 3'h0 && !(reg_wr && arr_hit_free) && free_reg[0] != 16'h0000)
    |=> free_reg[0] == $past(free_reg[0]) - 16'h0001)
    else $error("free count not decremented");
  AST_TD_WAIT: assert property (@(posedge core_clk) disable iff (reset)
    td_serve |-> !(rx_frame_busy && rx_frame_chan == td_sel))
    else $error("teardown during frame reception");
  AST_TD_COMPLETE: assert property (@(posedge core_clk) disable iff (reset)
    td_serve |=> rx_irq != 8'h00 && cp_reg[$past(td_sel)] == `ERX_TD_CP_VALUE
                 && hdp_reg[$past(td_sel)] == 32'h0000_0000 || $past(reg_wr))
    else $error("teardown completion state wrong");
  AST_TD_INACTIVE: assert property (@(posedge core_clk) disable iff (reset)
    (td_serve && !td_active) |=> !td_desc_flag_wr && $onehot(rx_irq))
    else $error("inactive teardown wrote a descriptor");
  AST_TD_ENABLES: assert property (@(posedge core_clk) disable iff (reset)
    (td_serve && !wr_set && !wr_clr) |=> $stable(chan_en_reg))
    else $error("teardown changed channel enables");
endmodule // erx_filter
`default_nettype wire

// [design/erx_hash.sv]
// Multicast hash index and table lookup
`timescale 1ns/1ns
`default_nettype none
module erx_hash (
  input  wire erx_pkg::erx_mac_t dest_addr,
  input  wire logic [31:0]       hash_lo,
  input  wire logic [31:0]       hash_hi,
  output logic [5:0]             hash_index,
  output logic                   hash_hit
);
  import erx_pkg::*;

  logic [63:0] table_bits;

  always_comb begin
    hash_index = 6'h00;
    for (int i = 0; i < 8; i++) begin
      hash_index = hash_index ^ dest_addr[i*6 +: 6];
    end
  end

  assign table_bits = {hash_hi, hash_lo};
  assign hash_hit   = table_bits[hash_index];
endmodule // erx_hash
`default_nettype wire

// [design/erx_map.svh]
// Register offsets, field positions and constants of the receive filter
`ifndef ERX_MAP_SVH
`define ERX_MAP_SVH

// ============================================================
// Register byte offsets
`define ERX_OFS_FILTER_CFG   8'h00
`define ERX_OFS_CHEN_SET     8'h04
`define ERX_OFS_CHEN_CLR     8'h08
`define ERX_OFS_HASH_LO      8'h0c
`define ERX_OFS_HASH_HI      8'h10
`define ERX_OFS_LOWPRIO_THR  8'h14
`define ERX_OFS_RAM_INDEX    8'h18
`define ERX_OFS_RAM_UPPER    8'h1c
`define ERX_OFS_RAM_LOWER    8'h20
`define ERX_OFS_TEARDOWN     8'h24
`define ERX_OFS_FREE_BASE    8'h40
`define ERX_OFS_HDP_BASE     8'h60
`define ERX_OFS_CP_BASE      8'h80
`define ERX_ARRAY_SPAN       8'h20

// ============================================================
// Filter configuration fields
`define ERX_CFG_MCH_LSB      0
`define ERX_CFG_MCAST_EN     5
`define ERX_CFG_BCH_LSB      8
`define ERX_CFG_BCAST_EN     13
`define ERX_CFG_PCH_LSB      16
`define ERX_CFG_ALL_EN       21
`define ERX_CFG_ERR_EN       22
`define ERX_CFG_CTRL_EN      23
`define ERX_CFG_SHORT_EN     24
`define ERX_CFG_QOS_EN       29
`define ERX_CFG_RESET        32'h0000_0000

// ============================================================
// Address RAM lower word fields
`define ERX_LOW_CH_LSB       16
`define ERX_LOW_MF_BIT       19
`define ERX_LOW_VALID_BIT    20

// ============================================================
// Frame constants
`define ERX_TPID_TAGGED      16'h8100
`define ERX_PRIO_MSB         15
`define ERX_GROUP_BIT        40
`define ERX_BCAST_ADDR       48'hffff_ffff_ffff
`define ERX_TD_CP_VALUE      32'hffff_fffc
`define ERX_FREE_MAX         16'hffff
`define ERX_NUM_CHAN         8
`define ERX_RAM_DEPTH        32

`endif

// [design/erx_pkg.sv]
// Types shared by the receive filter modules
package erx_pkg;
  typedef logic [2:0]  erx_chan_t;
  typedef logic [47:0] erx_mac_t;
  typedef enum logic [1:0] {
    ERX_ROUTE_DROP,
    ERX_ROUTE_MATCH,
    ERX_ROUTE_PROMISC
  } erx_route_e;
endpackage : erx_pkg

// [tb/erx_phy_model.sv]
// Far-side model: frames in reception and buffer use
`timescale 1ns/1ns
`default_nettype none
module erx_phy_model (
  input  wire logic               core_clk,
  input  wire logic               reset,
  input  wire logic               start,
  input  wire erx_pkg::erx_chan_t chan,
  input  wire logic [3:0]         nbuf,
  output logic                    buf_used,
  output erx_pkg::erx_chan_t      buf_used_chan,
  output logic                    rx_frame_busy,
  output erx_pkg::erx_chan_t      rx_frame_chan
);
  import erx_pkg::*;
  logic [3:0] left_reg;
  erx_chan_t  chan_reg;
  // ============================================================
  // Frame in progress
  // one buffer per busy cycle
  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      left_reg <= 4'h0;
      chan_reg <= 3'h0;
    end else if (start) begin
      left_reg <= nbuf;
      chan_reg <= chan;
    end else if (left_reg != 4'h0) begin
      left_reg <= left_reg - 4'h1;
    end
  end
  assign rx_frame_busy = (left_reg != 4'h0);
  assign buf_used      = rx_frame_busy;
  // Idle channel lines do not keep the last value
  assign buf_used_chan = rx_frame_busy ? chan_reg : ~chan_reg;
  assign rx_frame_chan = rx_frame_busy ? chan_reg : ~chan_reg;
endmodule // erx_phy_model
`default_nettype wire

// [tb/test_erx_filter.sv]
// Self-checking testbench of the receive channel filter
`timescale 1ns/1ns
`default_nettype none
`include "erx_map.svh"
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
module test_erx_filter;
  import erx_pkg::*;
  typedef struct packed {
    erx_mac_t d; logic [15:0] lt; logic [15:0] tci; logic [2:0] cse;
    logic acc; erx_chan_t ch; logic hi;
  } erx_case_s;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        hdr_valid = 1'b0;
  erx_mac_t    hdr_dest = 48'h0;
  logic [15:0] hdr_len_type = 16'h0;
  logic [15:0] hdr_tci = 16'h0;
  logic        hdr_is_control = 1'b0;
  logic        hdr_is_short = 1'b0;
  logic        hdr_has_error = 1'b0;
  logic        route_valid, route_accept, route_prio_high, buf_used, rx_frame_busy;
  erx_chan_t   route_chan, buf_used_chan, rx_frame_chan;
  logic [7:0]  rx_irq;
  logic        td_desc_flag_wr;
  logic [31:0] td_desc_ptr;
  logic        st = 1'b0;
  erx_chan_t   st_ch = 3'h0;
  logic [3:0]  st_n = 4'h0;
  logic [63:0] hv;
  int          err_count = 0;
  int          num_checks = 0;
  localparam erx_mac_t U = 48'h0011_2233_4455, F = 48'h0100_5e00_0001;
  localparam erx_mac_t G = 48'h0100_5e00_0002, M = 48'h0300_0000_0009;
  localparam erx_mac_t D = 48'h0011_2233_4466, X = 48'h0011_2233_4477;
  erx_case_s rows [13] = '{
    '{U, 16'h0800, 16'h0000, 3'b000, 1'b1, 3'd2, 1'b0},
    '{X, 16'h0800, 16'h0000, 3'b000, 1'b1, 3'd6, 1'b0},
    '{48'hffff_ffff_ffff, 16'h0800, 16'h0000, 3'b000, 1'b1, 3'd5, 1'b0},
    '{G, 16'h0800, 16'h0000, 3'b000, 1'b1, 3'd4, 1'b0},
    '{F, 16'h0800, 16'h0000, 3'b000, 1'b0, 3'd0, 1'b0},
    '{M, 16'h0800, 16'h0000, 3'b000, 1'b1, 3'd1, 1'b0},
    '{D, 16'h0800, 16'h0000, 3'b000, 1'b1, 3'd6, 1'b0},
    '{U, 16'h8100, 16'ha000, 3'b000, 1'b1, 3'd2, 1'b1},
    '{U, 16'h8100, 16'h6000, 3'b000, 1'b1, 3'd2, 1'b0},
    '{U, 16'h0800, 16'he000, 3'b000, 1'b1, 3'd2, 1'b0},
    '{U, 16'h0800, 16'h0000, 3'b100, 1'b0, 3'd0, 1'b0},
    '{X, 16'h0800, 16'h0000, 3'b010, 1'b0, 3'd0, 1'b0},
    '{U, 16'h0800, 16'h0000, 3'b001, 1'b0, 3'd0, 1'b0}};

  erx_filter i_erx_filter (.core_clk(core_clk), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .hdr_valid(hdr_valid), .hdr_dest(hdr_dest), .hdr_len_type(hdr_len_type),
    .hdr_tci(hdr_tci), .hdr_is_control(hdr_is_control), .hdr_is_short(hdr_is_short),
    .hdr_has_error(hdr_has_error), .route_valid(route_valid), .route_accept(route_accept),
    .route_chan(route_chan), .route_prio_high(route_prio_high), .buf_used(buf_used),
    .buf_used_chan(buf_used_chan), .rx_frame_busy(rx_frame_busy),
    .rx_frame_chan(rx_frame_chan), .rx_irq(rx_irq), .td_desc_flag_wr(td_desc_flag_wr),
    .td_desc_ptr(td_desc_ptr));
  erx_phy_model i_erx_phy_model (.core_clk(core_clk), .reset(reset), .start(st),
    .chan(st_ch), .nbuf(st_n), .buf_used(buf_used), .buf_used_chan(buf_used_chan),
    .rx_frame_busy(rx_frame_busy), .rx_frame_chan(rx_frame_chan));

  always #2 core_clk = ~core_clk;

  // ============================================================
  // Bus, frame and helper tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task automatic ram(input logic [4:0] i, input erx_mac_t m, input logic [2:0] c,
                     input logic mf, input logic v);
    wr(`ERX_OFS_RAM_INDEX, {27'h0, i});
    wr(`ERX_OFS_RAM_UPPER, m[47:16]);
    wr(`ERX_OFS_RAM_LOWER, {11'h0, v, mf, c, m[15:0]});
  endtask
  task automatic go(input erx_chan_t c, input logic [3:0] n);
    @(posedge core_clk);
    st <= 1'b1;
    st_ch <= c;
    st_n <= n;
    @(posedge core_clk);
    st <= 1'b0;
  endtask
  task automatic frame(input erx_case_s r);
    @(posedge core_clk);
    hdr_valid <= 1'b1;
    hdr_dest <= r.d;
    hdr_len_type <= r.lt;
    hdr_tci <= r.tci;
    {hdr_is_control, hdr_is_short, hdr_has_error} <= r.cse;
    @(posedge core_clk);
    hdr_valid <= 1'b0;
    #1;
    `CHK(route_valid, 1'b1)
    `CHK(route_accept, r.acc)
    `CHK(route_prio_high, r.hi)
    if (r.acc) `CHK(route_chan, r.ch)
  endtask
  task automatic tdown(input erx_chan_t c, input logic [31:0] hdp);
    logic b1, hit;
    hit = 1'b0;
    wr(`ERX_OFS_TEARDOWN, {29'h0, c});
    #1;
    // Busy seen one cycle before the pulse is the serve cycle
    b1 = rx_frame_busy;
    for (int i = 0; i < 40 && !hit; i++) begin
      @(posedge core_clk);
      #1;
      if (rx_irq[c] === 1'b1) hit = 1'b1;
      else begin
        b1 = rx_frame_busy;
      end
    end
    if (!hit) begin
      err_count++;
      final_report();
    end
    `CHK(b1, 1'b0)
    `CHK(rx_irq, 8'h1 << c)
    `CHK(td_desc_flag_wr, hdp != 32'h0)
    if (hdp != 32'h0) `CHK(td_desc_ptr, hdp)
    rd(`ERX_OFS_HDP_BASE + {c, 2'b00}, 32'h0);
    rd(`ERX_OFS_CP_BASE + {c, 2'b00}, `ERX_TD_CP_VALUE);
    rd(`ERX_OFS_CHEN_SET, 32'h77);
  endtask
  function automatic logic [5:0] hidx(input erx_mac_t m);
    hidx = 6'h0;
    for (int j = 0; j < 8; j++) hidx ^= m[j*6 +: 6];
  endfunction
  task automatic final_report;
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ============================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    rd(`ERX_OFS_FILTER_CFG, 32'h0);
    rd(8'hfc, 32'h0);
    $display("reset test done");
    // host set-up order, unused entries invalid
    for (int i = 0; i < 8; i++) wr(`ERX_OFS_HDP_BASE + 8'(4 * i), 32'h0);
    hv = (64'h1 << hidx(G)) | (64'h1 << hidx(F));
    wr(`ERX_OFS_HASH_LO, hv[31:0]);
    wr(`ERX_OFS_HASH_HI, hv[63:32]);
    wr(`ERX_OFS_HDP_BASE + 8'h08, 32'h0000_1000);
    ram(5'd0, U, 3'd2, 1'b1, 1'b1);
    ram(5'd1, F, 3'd7, 1'b0, 1'b1);
    ram(5'd2, M, 3'd1, 1'b1, 1'b1);
    ram(5'd3, D, 3'd3, 1'b1, 1'b1);
    for (int i = 4; i < 32; i++) ram(5'(i), 48'h0, 3'd0, 1'b0, 1'b0);
    wr(`ERX_OFS_FILTER_CFG, 32'h0026_2524);
    wr(`ERX_OFS_CHEN_SET, 32'hff);
    wr(`ERX_OFS_CHEN_CLR, 32'h88);
    rd(`ERX_OFS_CHEN_SET, 32'h77);
    foreach (rows[k]) frame(rows[k]);
    $display("routing table done");
    wr(8'h48, 32'h5);
    wr(8'h48, 32'h3);
    rd(8'h48, 32'h8);
    go(3'd2, 4'd3);
    repeat (6) @(posedge core_clk);
    rd(8'h48, 32'h5);
    wr(8'h40, 32'h1);
    go(3'd0, 4'd2);
    repeat (5) @(posedge core_clk);
    rd(8'h40, 32'h0);
    wr(8'h4c, 32'hffff);
    wr(8'h4c, 32'h1);
    rd(8'h4c, 32'hffff);
    $display("free counter test done");
    wr(`ERX_OFS_LOWPRIO_THR, 32'h5);
    wr(`ERX_OFS_FILTER_CFG, 32'h2026_2524);
    frame('{U, 16'h0800, 16'h0000, 3'b000, 1'b0, 3'd0, 1'b0});
    frame('{U, 16'h8100, 16'he000, 3'b000, 1'b1, 3'd2, 1'b1});
    wr(8'h48, 32'h1);
    frame('{U, 16'h0800, 16'h0000, 3'b000, 1'b1, 3'd2, 1'b0});
    $display("qos test done");
    go(3'd2, 4'd9);
    tdown(3'd2, 32'h0000_1000);
    tdown(3'd7, 32'h0);
    wr(`ERX_OFS_CP_BASE + 8'h1c, `ERX_TD_CP_VALUE);
    rd(`ERX_OFS_CP_BASE + 8'h1c, `ERX_TD_CP_VALUE);
    $display("teardown test done");
    final_report();
  end
endmodule // test_erx_filter
`default_nettype wire
